/* common/position_cmd_regs.vh */
// register map, field layout, reset values and timing constants of the position command front end
`ifndef POSITION_CMD_REGS_VH
`define POSITION_CMD_REGS_VH

`define REG_CTRL        8'h00
`define REG_MONSEL      8'h04
`define REG_ACC_TIME    8'h08
`define REG_DEC_TIME    8'h0c
`define REG_STOP_TIME   8'h10
`define REG_REF_FREQ    8'h14
`define REG_TERM_FUNC   8'h18
`define REG_STATUS      8'h1c
`define REG_MONITOR     8'h20
`define REG_TARGET      8'h24
`define REG_FEED_BASE   8'h40
`define REG_FEED_LAST   8'h78

`define CTRL_SRC        1:0
`define CTRL_FMT        4:2
`define CTRL_CLR_MODE   5
`define CTRL_W          6
`define CTRL_RESET      6'h20

`define FEED_LO         13:0
`define FEED_HI         29:16
`define DIGIT_W         14

`define MONSEL_RESET    14'h270f
`define MON_CMD_LO      14'h0000
`define MON_CMD_HI      14'h0001
`define MON_FB_LO       14'h0002
`define MON_FB_HI       14'h0003
`define MON_DROOP_LO    14'h0004
`define MON_DROOP_HI    14'h0005
`define MON_FREQ        14'h270f

`define TIME_W          13
`define TIME_RESET      13'h0032
`define TIME_STOP_RESET 13'h0000
`define TIME_MIN        13'h0001
`define TIME_MAX        13'h0e10
`define REF_RESET       16'h1770
`define REF_MIN         16'h0682

`define SRC_PULSE       2'h2
`define FMT_POS_MIN     3'h3
`define FN_SIGN         8'h44
`define FN_CLEAR        8'h45
`define TERM_FUNC_RESET 32'h0000_0000

`define CLK_MHZ         200
`define READY_DELAY_US  100000
`define RAMP_STEP_NS    390625
`define SPEED_MAX       8'hff
`define DEC_SCALE       32'h0000_2710

`endif

/* design/pin_sync.v */
// two-flop synchroniser for a group of asynchronous pins
module pin_sync #(
   parameter integer WIDTH = 1
) (
   input  wire             i_clk,
   input  wire             i_srst,
   input  wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_sync
);
   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   always @(posedge i_clk) begin
      if (i_srst) begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule

/* design/position_command_front_end.v */
// position command front end: stored feed moves, pulse-train input, clear, servo sequencing, monitor
// Function
// - fifteen stored feed amounts picked by select inputs
// - amount is upper times ten thousand plus lower
// - select inputs sampled at run command rise
// - late select changes ignored, no feed
// - run drop uses sudden-stop deceleration time
// - ramp times clamped to 0.1s..360s
// - reference frequency clamped at 16.66Hz minimum
// - position ramps are always linear
// - source 2 makes jog pin pulse input
// - sign from terminal with function 68
// - format 0-2 negative, 3-5 positive logic
// - servo-on releases shut-off, ready 0.1s later
// - stroke inputs on pass command pulses
// - stroke input off blocks that direction
// - clear mode 0 edge, mode 1 level
// - clear from terminal with function 69
// - monitor select picks count digits or frequency
// - pulses counted only while servo on
// - cumulative counters reset on shut-off or clear, deviation counter only on clear
`include "position_cmd_regs.vh"
module position_command_front_end #(
   parameter integer READY_CYCLES     = `READY_DELAY_US * `CLK_MHZ,
   parameter integer RAMP_TICK_CYCLES = `RAMP_STEP_NS * `CLK_MHZ / 1000
) (
   input  wire        i_clk,
   input  wire        i_srst,
   input  wire [7:0]  i_avs_address,
   input  wire        i_avs_read,
   input  wire        i_avs_write,
   input  wire [31:0] i_avs_writedata,
   input  wire [3:0]  i_avs_byteenable,
   output reg  [31:0] o_avs_readdata,
   output reg         o_avs_waitrequest,
   input  wire        i_forward_run_cmd,
   input  wire        i_reverse_run_cmd,
   input  wire        i_select_in_high,
   input  wire        i_select_in_middle,
   input  wire        i_select_in_low,
   input  wire        i_select_in_extra,
   input  wire        i_servo_on_input,
   input  wire        i_pulse_train_pin,
   input  wire [3:0]  i_term,
   input  wire        i_fb_pulse,
   input  wire        i_fb_dir,
   output reg         o_cmd_pulse,
   output reg         o_cmd_dir,
   output reg         o_base_enable,
   output reg         o_ready,
   output reg         o_moving
);
   localparam [1:0] MV_IDLE  = 2'h0;
   localparam [1:0] MV_MOVE  = 2'h1;
   localparam [1:0] MV_DECEL = 2'h2;
   localparam [1:0] MV_STOP  = 2'h3;

   function [7:0] be_lane;
      input [7:0] old_b;
      input [7:0] new_b;
      input       en;
      begin
         be_lane = en ? new_b : old_b;
      end
   endfunction

   function [`TIME_W-1:0] clamp_time;
      input [`TIME_W-1:0] t;
      begin
         if (t < `TIME_MIN)
            clamp_time = `TIME_MIN;
         else if (t > `TIME_MAX)
            clamp_time = `TIME_MAX;
         else
            clamp_time = t;
      end
   endfunction

   function term_pick;
      input [31:0] funcs;
      input [3:0]  terms;
      input [7:0]  code;
      integer      k;
      begin
         term_pick = 1'b0;
         for (k = 3; k >= 0; k = k - 1) begin
            if (funcs[k*8 +: 8] == code)
               term_pick = terms[k];
         end
      end
   endfunction

   function [31:0] digits;
      input [31:0] value;
      input        upper;
      reg   [31:0] mag;
      begin
         mag = value[31] ? (~value + 32'h0000_0001) : value;
         digits = upper ? ((mag / `DEC_SCALE) % `DEC_SCALE) : (mag % `DEC_SCALE);
      end
   endfunction

   // pin synchronisers
   wire [13:0] sy;
   pin_sync #(.WIDTH(14)) u_sync (
      .i_clk   (i_clk),
      .i_srst  (i_srst),
      .i_async ({i_fb_dir, i_fb_pulse, i_term, i_pulse_train_pin, i_servo_on_input, i_select_in_extra,
                 i_select_in_high, i_select_in_middle, i_select_in_low, i_reverse_run_cmd, i_forward_run_cmd}),
      .o_sync  (sy)
   );
   wire       s_fwd   = sy[0];
   wire       s_rev   = sy[1];
   wire [3:0] s_sel   = {sy[5], sy[4], sy[3], sy[2]};
   wire       s_servo = sy[6];
   wire       s_pin   = sy[7];
   wire [3:0] s_term  = sy[11:8];
   wire       s_fbp   = sy[12];
   wire       s_fbd   = sy[13];

   // registers
   reg  [`CTRL_W-1:0]  ctrl_q;
   reg  [`DIGIT_W-1:0] monsel_q;
   reg  [`TIME_W-1:0]  acc_q;
   reg  [`TIME_W-1:0]  dec_q;
   reg  [`TIME_W-1:0]  stop_q;
   reg  [15:0]         ref_q;
   reg  [31:0]         termf_q;
   reg  [`DIGIT_W-1:0] feed_lo [1:15];
   reg  [`DIGIT_W-1:0] feed_hi [1:15];
   reg  [26:0]         target_q;
   reg  [31:0]         cum_cmd_q;
   reg  [31:0]         cum_fb_q;
   reg  [31:0]         droop_q;
   reg  [31:0]         ready_cnt_q;
   reg  [1:0]          state_q;
   reg  [7:0]          speed_q;
   reg  [15:0]         phase_q;
   reg  [26:0]         remain_q;
   reg  [26:0]         acc_dist_q;
   reg  [31:0]         tick_cnt_q;
   reg  [`TIME_W-1:0]  step_cnt_q;
   reg                 run_d_q;
   reg                 pin_d_q;
   reg                 fbp_d_q;
   reg                 clr_d_q;
   reg  [31:0]         rd_mux;
   reg  [31:0]         mon_val;
   integer             i;

   wire        src_pulse = (ctrl_q[`CTRL_SRC] == `SRC_PULSE);
   wire        pos_logic = (ctrl_q[`CTRL_FMT] >= `FMT_POS_MIN);
   wire [3:0]  feed_idx  = i_avs_address[5:2] + 4'h1;
   wire        in_feed   = (i_avs_address >= `REG_FEED_BASE) && (i_avs_address <= `REG_FEED_LAST);
   wire [`TIME_W-1:0] acc_c  = clamp_time(acc_q);
   wire [`TIME_W-1:0] dec_c  = clamp_time(dec_q);
   wire [`TIME_W-1:0] stop_c = clamp_time(stop_q);
   wire [15:0] ref_c = (ref_q < `REF_MIN) ? `REF_MIN : ref_q;
   wire [23:0] freq_prod = speed_q * ref_c;
   wire [15:0] out_freq  = freq_prod[23:8];

   // select decode: RH, RM, RL alone are 1..3, pairs 4..6, all three 7, extra adds the upper half
   reg  [3:0]  sel_idx;
   always @* begin
      case (s_sel)
         4'b0100: sel_idx = 4'h1;
         4'b0010: sel_idx = 4'h2;
         4'b0001: sel_idx = 4'h3;
         4'b0011: sel_idx = 4'h4;
         4'b0101: sel_idx = 4'h5;
         4'b0110: sel_idx = 4'h6;
         4'b0111: sel_idx = 4'h7;
         default: sel_idx = s_sel[3] ? {1'b1, s_sel[2:0]} : 4'h0;
      endcase
   end
   wire [26:0] sel_amount = (sel_idx == 4'h0) ? 27'h0 :
                            ({13'h0, feed_hi[sel_idx]} * 27'h0002710 + {13'h0, feed_lo[sel_idx]});

   // terminal functions and pulse train decode
   wire s_sign  = term_pick(termf_q, s_term, `FN_SIGN);
   wire s_clear = term_pick(termf_q, s_term, `FN_CLEAR);
   wire pt_edge = pos_logic ? (s_pin & ~pin_d_q) : (~s_pin & pin_d_q);
   wire pt_fwd  = pos_logic ? s_sign : ~s_sign;
   wire pt_ok   = pt_fwd ? s_fwd : s_rev;
   wire pt_pulse = src_pulse & o_ready & pt_edge & pt_ok;
   wire fb_pulse = s_fbp & ~fbp_d_q;
   wire clr_rise = s_clear & ~clr_d_q;

   // internal pulse generator
   wire        run_lvl  = s_fwd | s_rev;
   wire        run_rise = run_lvl & ~run_d_q;
   wire [16:0] phase_sum = {1'b0, phase_q} + {9'h0, speed_q};
   // gated by ready so that no pulse leaks out in the cycle after ready falls
   wire        pg_pulse = o_ready & (state_q != MV_IDLE) & phase_sum[16] & (remain_q != 27'h0);
   wire        ramp_tick = (tick_cnt_q == RAMP_TICK_CYCLES - 1);
   reg  [`TIME_W-1:0] period;
   always @* begin
      case (state_q)
         MV_MOVE:  period = acc_c;
         MV_DECEL: period = dec_c;
         MV_STOP:  period = stop_c;
         default:  period = acc_c;
      endcase
   end
   wire ramp_step = ramp_tick & (step_cnt_q + 13'h0001 >= period);
   wire out_pulse = pg_pulse | pt_pulse;
   wire out_dir   = src_pulse ? pt_fwd : o_cmd_dir;

   // register read mux
   always @* begin
      rd_mux = 32'h0;
      if (in_feed && i_avs_address[1:0] == 2'h0) begin
         rd_mux[`FEED_LO] = feed_lo[feed_idx];
         rd_mux[`FEED_HI] = feed_hi[feed_idx];
      end else begin
         case (i_avs_address)
            `REG_CTRL:      rd_mux = {26'h0, ctrl_q};
            `REG_MONSEL:    rd_mux = {18'h0, monsel_q};
            `REG_ACC_TIME:  rd_mux = {19'h0, acc_q};
            `REG_DEC_TIME:  rd_mux = {19'h0, dec_q};
            `REG_STOP_TIME: rd_mux = {19'h0, stop_q};
            `REG_REF_FREQ:  rd_mux = {16'h0, ref_q};
            `REG_TERM_FUNC: rd_mux = termf_q;
            `REG_STATUS:    rd_mux = {26'h0, state_q, o_cmd_dir, o_moving, o_ready, o_base_enable};
            `REG_MONITOR:   rd_mux = mon_val;
            `REG_TARGET:    rd_mux = {5'h0, target_q};
            default:        rd_mux = 32'h0;
         endcase
      end
   end

   always @* begin
      case (monsel_q)
         `MON_CMD_LO:   mon_val = digits(cum_cmd_q, 1'b0);
         `MON_CMD_HI:   mon_val = digits(cum_cmd_q, 1'b1);
         `MON_FB_LO:    mon_val = digits(cum_fb_q, 1'b0);
         `MON_FB_HI:    mon_val = digits(cum_fb_q, 1'b1);
         `MON_DROOP_LO: mon_val = digits(droop_q, 1'b0);
         `MON_DROOP_HI: mon_val = digits(droop_q, 1'b1);
         `MON_FREQ:     mon_val = {16'h0, out_freq};
         default:       mon_val = 32'h0;
      endcase
   end

   wire [31:0] wmerge = {be_lane(rd_mux[31:24], i_avs_writedata[31:24], i_avs_byteenable[3]),
                         be_lane(rd_mux[23:16], i_avs_writedata[23:16], i_avs_byteenable[2]),
                         be_lane(rd_mux[15:8],  i_avs_writedata[15:8],  i_avs_byteenable[1]),
                         be_lane(rd_mux[7:0],   i_avs_writedata[7:0],   i_avs_byteenable[0])};
   wire        req = i_avs_read | i_avs_write;
   wire        wr  = i_avs_write & ~o_avs_waitrequest;

   // bus slave: answer one cycle after the request is seen, write lands on the accepting edge
   always @(posedge i_clk) begin
      if (i_srst) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata    <= 32'h0;
         ctrl_q            <= `CTRL_RESET;
         monsel_q          <= `MONSEL_RESET;
         acc_q             <= `TIME_RESET;
         dec_q             <= `TIME_RESET;
         stop_q            <= `TIME_STOP_RESET;
         ref_q             <= `REF_RESET;
         termf_q           <= `TERM_FUNC_RESET;
         for (i = 1; i <= 15; i = i + 1) begin
            feed_lo[i] <= {`DIGIT_W{1'b0}};
            feed_hi[i] <= {`DIGIT_W{1'b0}};
         end
      end else begin
         if (req && o_avs_waitrequest) begin
            o_avs_waitrequest <= 1'b0;
            o_avs_readdata    <= rd_mux;
         end else begin
            o_avs_waitrequest <= 1'b1;
         end
         if (wr) begin
            if (in_feed && i_avs_address[1:0] == 2'h0) begin
               feed_lo[feed_idx] <= wmerge[`FEED_LO];
               feed_hi[feed_idx] <= wmerge[`FEED_HI];
            end else begin
               case (i_avs_address)
                  `REG_CTRL:      ctrl_q   <= wmerge[`CTRL_W-1:0];
                  `REG_MONSEL:    monsel_q <= wmerge[`DIGIT_W-1:0];
                  `REG_ACC_TIME:  acc_q    <= wmerge[`TIME_W-1:0];
                  `REG_DEC_TIME:  dec_q    <= wmerge[`TIME_W-1:0];
                  `REG_STOP_TIME: stop_q   <= wmerge[`TIME_W-1:0];
                  `REG_REF_FREQ:  ref_q    <= wmerge[15:0];
                  `REG_TERM_FUNC: termf_q  <= wmerge;
                  default:        ctrl_q   <= ctrl_q;
               endcase
            end
         end
      end
   end

   // servo-on sequencing
   always @(posedge i_clk) begin
      if (i_srst) begin
         o_base_enable <= 1'b0;
         o_ready       <= 1'b0;
         ready_cnt_q   <= 32'h0;
      end else begin
         o_base_enable <= s_servo;
         if (!s_servo || !o_base_enable) begin
            o_ready     <= 1'b0;
            ready_cnt_q <= 32'h0;
         end else if (ready_cnt_q == READY_CYCLES - 1) begin
            o_ready <= 1'b1;
         end else begin
            ready_cnt_q <= ready_cnt_q + 32'h0000_0001;
         end
      end
   end

   // stored-feed move: trapezoid with linear slopes
   always @(posedge i_clk) begin
      if (i_srst) begin
         state_q    <= MV_IDLE;
         speed_q    <= 8'h00;
         phase_q    <= 16'h0;
         remain_q   <= 27'h0;
         acc_dist_q <= 27'h0;
         target_q   <= 27'h0;
         tick_cnt_q <= 32'h0;
         step_cnt_q <= {`TIME_W{1'b0}};
         run_d_q    <= 1'b0;
         o_moving   <= 1'b0;
      end else begin
         run_d_q    <= run_lvl;
         tick_cnt_q <= ramp_tick ? 32'h0 : tick_cnt_q + 32'h0000_0001;
         if (ramp_tick)
            step_cnt_q <= ramp_step ? {`TIME_W{1'b0}} : step_cnt_q + 13'h0001;
         phase_q  <= (state_q == MV_IDLE) ? 16'h0 : phase_sum[15:0];
         if (pg_pulse) begin
            remain_q <= remain_q - 27'h0000001;
            if (state_q == MV_MOVE && speed_q != `SPEED_MAX)
               acc_dist_q <= acc_dist_q + 27'h0000001;
         end
         o_moving <= o_ready & (state_q != MV_IDLE);
         if (!o_ready) begin
            state_q <= MV_IDLE;
            speed_q <= 8'h00;
         end else begin
            case (state_q)
               MV_IDLE: begin
                  if (run_rise && !src_pulse && sel_amount != 27'h0) begin
                     target_q   <= sel_amount;
                     remain_q   <= sel_amount;
                     acc_dist_q <= 27'h0;
                     speed_q    <= 8'h01;
                     step_cnt_q <= {`TIME_W{1'b0}};
                     state_q    <= MV_MOVE;
                  end
               end
               MV_MOVE: begin
                  if (!run_lvl)
                     state_q <= MV_STOP;
                  else if (remain_q <= acc_dist_q)
                     state_q <= MV_DECEL;
                  else if (ramp_step && speed_q != `SPEED_MAX)
                     speed_q <= speed_q + 8'h01;
               end
               MV_DECEL: begin
                  if (!run_lvl)
                     state_q <= MV_STOP;
                  else if (remain_q == 27'h0) begin
                     speed_q <= 8'h00;
                     state_q <= MV_IDLE;
                  end else if (ramp_step && speed_q > 8'h01)
                     speed_q <= speed_q - 8'h01;
               end
               MV_STOP: begin
                  if (speed_q == 8'h00 || remain_q == 27'h0) begin
                     speed_q <= 8'h00;
                     state_q <= MV_IDLE;
                  end else if (ramp_step)
                     speed_q <= speed_q - 8'h01;
               end
               default: state_q <= MV_IDLE;
            endcase
         end
      end
   end

   // command output, cumulative counters and deviation counter
   always @(posedge i_clk) begin
      if (i_srst) begin
         o_cmd_pulse <= 1'b0;
         o_cmd_dir   <= 1'b1;
         cum_cmd_q   <= 32'h0;
         cum_fb_q    <= 32'h0;
         droop_q     <= 32'h0;
         pin_d_q     <= 1'b0;
         fbp_d_q     <= 1'b0;
         clr_d_q     <= 1'b0;
      end else begin
         pin_d_q     <= s_pin;
         fbp_d_q     <= s_fbp;
         clr_d_q     <= s_clear;
         o_cmd_pulse <= out_pulse;
         if (src_pulse && pt_pulse)
            o_cmd_dir <= pt_fwd;
         else if (!src_pulse && state_q == MV_IDLE && run_rise)
            o_cmd_dir <= s_fwd;
         if (!o_base_enable || s_clear) begin
            cum_cmd_q <= 32'h0;
            cum_fb_q  <= 32'h0;
         end else begin
            if (out_pulse)
               cum_cmd_q <= out_dir ? cum_cmd_q + 32'h0000_0001 : cum_cmd_q - 32'h0000_0001;
            if (fb_pulse)
               cum_fb_q <= s_fbd ? cum_fb_q + 32'h0000_0001 : cum_fb_q - 32'h0000_0001;
         end
         if ((ctrl_q[`CTRL_CLR_MODE] && s_clear) || (!ctrl_q[`CTRL_CLR_MODE] && clr_rise))
            droop_q <= 32'h0;
         else if (o_base_enable)
            droop_q <= droop_q + ((out_pulse && out_dir) ? 32'h0000_0001 : 32'h0)
                               - ((out_pulse && !out_dir) ? 32'h0000_0001 : 32'h0)
                               - ((fb_pulse && s_fbd) ? 32'h0000_0001 : 32'h0)
                               + ((fb_pulse && !s_fbd) ? 32'h0000_0001 : 32'h0);
      end
   end
endmodule

/* tb/pcfe_asserts.sv */
// concurrent checks on the ports of the position command front end
module pcfe_asserts #(
   parameter integer READY_CYCLES = 20
) (
   input wire i_clk,
   input wire i_srst,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire o_avs_waitrequest,
   input wire i_servo_on_input,
   input wire o_cmd_pulse,
   input wire o_base_enable,
   input wire o_ready,
   input wire o_moving
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   int cnt_q;
   // cycles spent with shut-off released but not yet ready
   always @(posedge i_clk) cnt_q <= (o_base_enable && !o_ready) ? cnt_q + 1 : 0;
   a_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("waitrequest did not drop one cycle after a request");
   a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_wait_idle: assert property (!(i_avs_read || i_avs_write) && o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest dropped with no request");
   a_base_follow: assert property ($rose(i_servo_on_input) |-> ##[2:4] o_base_enable)
      else $error("shut-off not released after servo on");
   a_base_drop: assert property ($fell(i_servo_on_input) |-> ##[2:4] !o_base_enable)
      else $error("shut-off not applied after servo off");
   a_ready_delay: assert property ($rose(o_ready) |-> cnt_q >= READY_CYCLES - 1 && cnt_q <= READY_CYCLES + 1)
      else $error("ready delay after shut-off release is wrong");
   a_ready_base: assert property (o_ready |-> $past(o_base_enable))
      else $error("ready without shut-off released");
   a_pulse_ready: assert property (o_cmd_pulse |-> $past(o_ready))
      else $error("command pulse while not ready");
   a_move_ready: assert property (o_moving |-> $past(o_ready))
      else $error("move in progress while not ready");
   a_pulse_short: assert property (o_cmd_pulse |=> !o_cmd_pulse)
      else $error("command pulse longer than one cycle");
endmodule

bind position_command_front_end pcfe_asserts #(.READY_CYCLES(READY_CYCLES)) i_chk (
   .i_clk(i_clk), .i_srst(i_srst), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .o_avs_waitrequest(o_avs_waitrequest), .i_servo_on_input(i_servo_on_input), .o_cmd_pulse(o_cmd_pulse),
   .o_base_enable(o_base_enable), .o_ready(o_ready), .o_moving(o_moving));

/* tb/pulse_controller.sv */
// positioning controller model driving run, select, pulse, sign and clear pins
module pulse_controller (
   input  wire        i_clk,
   output logic       o_run_fwd,
   output logic       o_run_rev,
   output logic [3:0] o_sel,
   output logic       o_pulse,
   output logic       o_sign,
   output logic       o_clear
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {o_run_fwd, o_run_rev, o_sel, o_pulse, o_sign, o_clear} = 9'h000;
   task automatic set_sel(input logic [3:0] s);
      @(posedge i_clk) o_sel <= s;
   endtask
   // selects settle well before the run edge
   task automatic start(input logic [3:0] s, input bit fwd);
      set_sel(s);
      repeat (4) @(posedge i_clk);
      if (fwd) o_run_fwd <= 1'b1;
      else o_run_rev <= 1'b1;
   endtask
   task automatic stop();
      @(posedge i_clk) {o_run_fwd, o_run_rev} <= 2'b00;
   endtask
   // idle at !act first, so only the n active edges count
   task automatic pulses(input int n, input bit act, input bit sgn);
      @(posedge i_clk) begin
         o_sign <= sgn;
         o_pulse <= !act;
      end
      repeat (n) begin
         repeat (3) @(posedge i_clk);
         o_pulse <= act;
         repeat (3) @(posedge i_clk);
         o_pulse <= !act;
      end
      repeat (6) @(posedge i_clk);
   endtask
   task automatic clear(input int hold = 4);
      @(posedge i_clk) o_clear <= 1'b1;
      repeat (hold) @(posedge i_clk);
      o_clear <= 1'b0;
      repeat (4) @(posedge i_clk);
   endtask
endmodule

/* tb/testbench.sv */
// self-checking bench for the position command front end
`include "position_cmd_regs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, srst = 1, rd = 0, wt = 0, servo = 0, fbp = 0, fbd = 1;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [3:0] be = 4'hf;
   wire [31:0] rdat;
   wire wreq, cpul, cdir, base, rdy, mov, runf, runr, pul, sgn, clr;
   wire [3:0] sel;
   wire [1:0] st = {rdy, mov};
   int n_errors = 0, checks_done = 0, pcnt = 0, seed = 79677, n, ex[6];
   logic [31:0] rq[$];
   string rn[$];
   int mq[$];
   always #2.5 clk = ~clk;
   pulse_controller i_ctl (.i_clk(clk), .o_run_fwd(runf), .o_run_rev(runr), .o_sel(sel), .o_pulse(pul),
      .o_sign(sgn), .o_clear(clr));
   position_command_front_end #(.READY_CYCLES(20), .RAMP_TICK_CYCLES(4)) i_dut (
      .i_clk(clk), .i_srst(srst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wt),
      .i_avs_writedata(wdat), .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
      .i_forward_run_cmd(runf), .i_reverse_run_cmd(runr), .i_select_in_high(sel[2]),
      .i_select_in_middle(sel[1]), .i_select_in_low(sel[0]), .i_select_in_extra(sel[3]),
      .i_servo_on_input(servo), .i_pulse_train_pin(pul), .i_term({2'b00, clr, sgn}), .i_fb_pulse(fbp),
      .i_fb_dir(fbd), .o_cmd_pulse(cpul), .o_cmd_dir(cdir), .o_base_enable(base), .o_ready(rdy), .o_moving(mov));
   task chk(string nm, logic [31:0] s, logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   task tally_and_finish();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // for a read, d is the expected data
   task automatic bus(bit w, logic [7:0] a, logic [31:0] d, string nm = "", logic [3:0] b = 4'hf);
      int k = 0;
      if (!w) begin
         rq.push_back(d);
         rn.push_back(nm);
      end
      @(posedge clk) begin
         adr <= a;
         wdat <= w ? d : 32'h0;
         rd <= !w;
         wt <= w;
         be <= b;
      end
      do begin
         @(posedge clk);
         k++;
      end while (wreq !== 1'b0 && k < 20);
      if (k >= 20) chk("bus answer", 32'h0, 32'h1);
      rd <= 1'b0;
      wt <= 1'b0;
   endtask
   task automatic wait_lvl(int w, logic v, int lim);
      int k = 0;
      while (st[w] !== v && k < lim) begin
         @(posedge clk);
         k++;
      end
      chk("wait level", k < lim, 32'h1);
   endtask
   always @(posedge clk) begin
      if (rd && wreq === 1'b0) chk(rn.pop_front(), rdat, rq.pop_front());
      if ($fell(mov) && mq.size() > 0) chk("move count", pcnt + (cpul === 1'b1), mq.pop_front());
      pcnt <= $rose(mov) ? 0 : pcnt + (cpul === 1'b1);
   end
   initial begin
      repeat (60000) @(posedge clk);
      chk("watchdog", 32'h0, 32'h1);
      tally_and_finish();
   end
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      bus(0, `REG_CTRL, 32'h20, "ctrl");
      bus(0, `REG_MONSEL, 32'h270f, "monsel");
      bus(0, `REG_STOP_TIME, 32'h0, "stop time");
      bus(0, `REG_REF_FREQ, 32'h1770, "ref freq");
      bus(0, 8'h3c, 32'h0, "unmapped");
      bus(1, `REG_CTRL, 32'h0, "", 4'h0);
      bus(0, `REG_CTRL, 32'h20, "ctrl lanes");
      $display("test registers done");
      bus(1, `REG_ACC_TIME, 32'h1);
      bus(1, `REG_DEC_TIME, 32'h1);
      bus(1, `REG_TERM_FUNC, 32'h4544);
      bus(1, `REG_FEED_BASE + 8'h04, 32'h4); // one line, one turn, four edges
      bus(1, `REG_FEED_BASE, 32'h1_0003);
      @(posedge clk) servo <= 1'b1;
      wait_lvl(1, 1'b1, 100);
      mq.push_back(4);
      i_ctl.start(4'b0010, 1);
      wait_lvl(0, 1'b1, 20);
      i_ctl.set_sel(4'b0100);
      bus(0, `REG_TARGET, 32'h4, "late select");
      wait_lvl(0, 1'b0, 20000);
      i_ctl.stop();
      n = {$random(seed)} % 8 + 1;
      repeat (n) begin
         @(posedge clk) fbp <= 1'b1;
         repeat (3) @(posedge clk);
         fbp <= 1'b0;
         repeat (3) @(posedge clk);
      end
      ex = '{4, 0, n, 0, (n > 4) ? n - 4 : 4 - n, 0};
      foreach (ex[i]) begin
         bus(1, `REG_MONSEL, i);
         bus(0, `REG_MONITOR, ex[i], "monitor");
      end
      $display("test stored move done");
      i_ctl.start(4'b0100, 1);
      wait_lvl(0, 1'b1, 20);
      bus(0, `REG_TARGET, 32'h2713, "target");
      i_ctl.stop();
      wait_lvl(0, 1'b0, 3000);
      i_ctl.clear();
      bus(1, `REG_MONSEL, `MON_CMD_LO);
      bus(0, `REG_MONITOR, 32'h0, "cleared");
      // edge mode: droop zeroed once, then feedback counts while clear stays high
      bus(1, `REG_CTRL, 32'h0);
      fork
         i_ctl.clear(30);
         repeat (2) begin
            repeat (8) @(posedge clk);
            fbp <= 1'b1;
            repeat (3) @(posedge clk);
            fbp <= 1'b0;
         end
      join
      bus(1, `REG_MONSEL, `MON_DROOP_LO);
      bus(0, `REG_MONITOR, 32'h2, "edge clear");
      bus(1, `REG_MONSEL, `MON_CMD_LO);
      bus(1, `REG_CTRL, 32'h2e);
      i_ctl.start(4'h0, 1);
      i_ctl.pulses(5, 1, 1);
      i_ctl.pulses(3, 1, 0);
      bus(0, `REG_MONITOR, 32'h5, "stroke");
      i_ctl.start(4'h0, 0);
      i_ctl.pulses(2, 1, 0);
      chk("cmd dir rev", cdir, 32'h0);
      bus(1, `REG_CTRL, 32'h22);
      i_ctl.pulses(4, 0, 0);
      chk("cmd dir neg", cdir, 32'h1);
      bus(0, `REG_MONITOR, 32'h7, "neg logic");
      bus(1, `REG_CTRL, 32'h20);
      i_ctl.pulses(2, 1, 1);
      bus(0, `REG_MONITOR, 32'h7, "source off");
      $display("test pulse train done");
      @(posedge clk) servo <= 1'b0;
      repeat (8) @(posedge clk);
      bus(1, `REG_CTRL, 32'h2e);
      i_ctl.pulses(3, 1, 1);
      bus(0, `REG_MONITOR, 32'h0, "servo off");
      i_ctl.stop();
      $display("test servo off done");
      tally_and_finish();
   end
endmodule
